/* File: inc/asc_pkg.sv */
package asc_pkg;

  // ****************************************************************
  // control word layout
  // ****************************************************************
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned POS_CHAN_MSB = 4;
  localparam int unsigned POS_CHAN_MID = 3;
  localparam int unsigned POS_CHAN_LSB = 2;
  localparam int unsigned POS_SW_START = 1;
  localparam int unsigned POS_PWR_DOWN = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // ****************************************************************
  // serial frame edge counts
  // ****************************************************************
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] EDGE_START_BIT = 3'h4;
  localparam logic [CNT_W-1:0] EDGE_COMMIT = 3'h6;
  localparam logic [CNT_W-1:0] EDGE_STANDBY = 3'h7;
  localparam logic [CNT_W-1:0] EDGE_WORD_DONE = 3'h5;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned MCLK_PERIOD_NS = 4;
  localparam int unsigned HOLDOFF_NS = 2000;
  localparam int unsigned HOLDOFF_CYCLES = (HOLDOFF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [2:0] chan_sel;
    logic software_start_bit;
    logic power_down_bit;
  } asc_ctrl_s;

  typedef enum logic [1:0] {
    HO_EXPIRED = 2'b00,
    HO_HELD = 2'b01,
    HO_TIMING = 2'b10
  } asc_holdoff_e;

endpackage : asc_pkg

/* File: hw/asc_ctrl_reg.sv */
`timescale 1ns/1ns
module asc_ctrl_reg #(
  parameter int unsigned HOLDOFF_LEN = asc_pkg::HOLDOFF_CYCLES
) (
  // system
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // serial link
  input wire logic sclk_i,
  input wire logic write_frame_strobe_n_i,
  input wire logic sdata_i,
  // conversion control
  input wire logic hardware_start_n_i,
  input wire logic software_start_bit_done_i,
  output logic [2:0] chan_sel_o,
  output logic power_down_o,
  output logic holdoff_timing_cap_o,
  output logic track_hold_o,
  output logic software_start_bit_start_o
);

  initial begin
    if (HOLDOFF_LEN < 1) begin
      $error("holdoff length must be at least one cycle");
    end
  end

  // ****************************************************************
  // link side, clocked by the serial clock falling edge
  // ****************************************************************
  logic armed_q;
  logic [asc_pkg::CNT_W-1:0] cnt_q;
  logic [asc_pkg::CTRL_W-1:0] sr_q;
  logic reached6_q;
  logic reached7_q;

  // armed between frames so the first edge restarts the count
  always_ff @(negedge sclk_i or posedge write_frame_strobe_n_i) begin
    if (write_frame_strobe_n_i) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b0;
    end
  end

  // edge counter, saturates at seven
  always_ff @(negedge sclk_i) begin
    if (!write_frame_strobe_n_i) begin
      if (armed_q) begin
        cnt_q <= 3'h1;
      end else if (cnt_q != asc_pkg::EDGE_STANDBY) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // shift in five bits msb first, then hold still
  always_ff @(negedge sclk_i) begin
    if (!write_frame_strobe_n_i) begin
      if (armed_q) begin
        sr_q <= {4'h0, sdata_i};
      end else if (cnt_q < asc_pkg::EDGE_WORD_DONE) begin
        sr_q <= {sr_q[asc_pkg::CTRL_W-2:0], sdata_i};
      end
    end
  end

  // milestone levels, cleared when the frame ends
  always_ff @(negedge sclk_i or posedge write_frame_strobe_n_i) begin
    if (write_frame_strobe_n_i) begin
      reached6_q <= 1'b0;
      reached7_q <= 1'b0;
    end else if (!armed_q) begin
      if (cnt_q == asc_pkg::EDGE_COMMIT - 3'h1) begin
        reached6_q <= 1'b1;
      end
      if (cnt_q == asc_pkg::EDGE_STANDBY - 3'h1) begin
        reached7_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // synchronisers into the system clock
  // ****************************************************************
  logic [1:0] fs_sync_q;
  logic [1:0] r6_sync_q;
  logic [1:0] r7_sync_q;
  logic [1:0] hw_sync_q;
  logic fs_prev_q;
  logic hw_prev_q;

  // two flops per asynchronous level
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fs_sync_q <= 2'h3;
      r6_sync_q <= 2'h0;
      r7_sync_q <= 2'h0;
      hw_sync_q <= 2'h3;
    end else if (ce_i) begin
      fs_sync_q <= {fs_sync_q[0], write_frame_strobe_n_i};
      r6_sync_q <= {r6_sync_q[0], reached6_q};
      r7_sync_q <= {r7_sync_q[0], reached7_q};
      hw_sync_q <= {hw_sync_q[0], hardware_start_n_i};
    end
  end

  // previous values for edge detection
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fs_prev_q <= 1'b1;
      hw_prev_q <= 1'b1;
    end else if (ce_i) begin
      fs_prev_q <= fs_sync_q[1];
      hw_prev_q <= hw_sync_q[1];
    end
  end

  logic frame_start;
  logic frame_end;
  logic hw_rise;
  assign frame_start = fs_prev_q && !fs_sync_q[1];
  assign frame_end = !fs_prev_q && fs_sync_q[1];
  assign hw_rise = !hw_prev_q && hw_sync_q[1];

  // ****************************************************************
  // commit decisions
  // ****************************************************************
  logic seen6_q;
  logic seen7_q;
  logic commit6;
  logic commit7;
  logic short_software_start_bit;

  // link data is stable here: sclk stands still once the strobe is high,
  // and armed_q is already set again by then, so it is not consulted
  assign commit6 = !seen6_q && (r6_sync_q[1] ||
    (frame_end && cnt_q >= asc_pkg::EDGE_COMMIT));
  assign commit7 = !seen7_q && (r7_sync_q[1] ||
    (frame_end && cnt_q == asc_pkg::EDGE_STANDBY));
  // short frame still converts when the start bit arrived
  logic short_start_bit;
  assign short_start_bit = (cnt_q == asc_pkg::EDGE_START_BIT) ? sr_q[0] : sr_q[1];
  assign short_software_start_bit = frame_end && !seen6_q && cnt_q >= asc_pkg::EDGE_START_BIT &&
    cnt_q < asc_pkg::EDGE_COMMIT && short_start_bit;

  // once-per-frame flags
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      seen6_q <= 1'b0;
      seen7_q <= 1'b0;
    end else if (ce_i) begin
      if (frame_start) begin
        seen6_q <= 1'b0;
        seen7_q <= 1'b0;
      end else begin
        if (commit6) begin
          seen6_q <= 1'b1;
        end
        if (commit7) begin
          seen7_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  asc_pkg::asc_ctrl_s ctrl_q;

  // channel and start bits at six, standby at seven
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ctrl_q <= asc_pkg::CTRL_RESET;
    end else if (ce_i) begin
      if (commit6) begin
        ctrl_q.chan_sel <= sr_q[asc_pkg::POS_CHAN_MSB:asc_pkg::POS_CHAN_LSB];
        ctrl_q.software_start_bit <= sr_q[asc_pkg::POS_SW_START];
      end
      if (commit7) begin
        ctrl_q.power_down_bit <= sr_q[asc_pkg::POS_PWR_DOWN];
      end
    end
  end
  // fewer than six edges leave ctrl_q untouched

  // ****************************************************************
  // holdoff pulse and conversion launch
  // ****************************************************************
  asc_pkg::asc_holdoff_e ho_q;
  logic [31:0] ho_cnt_q;
  logic pend_q;
  logic timer_go;
  logic sw_req;

  assign sw_req = (commit6 && sr_q[asc_pkg::POS_SW_START]) || short_software_start_bit;
  assign timer_go = commit6 || short_software_start_bit;

  // holdoff state: low at frame start, timed from the sixth edge or from the end of a short frame with the start bit
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ho_q <= asc_pkg::HO_EXPIRED;
      ho_cnt_q <= 32'h0;
    end else if (ce_i) begin
      case (ho_q)
        asc_pkg::HO_EXPIRED: begin
          if (frame_start) begin
            ho_q <= asc_pkg::HO_HELD;
          end
        end
        asc_pkg::HO_HELD: begin
          if (timer_go) begin
            ho_q <= asc_pkg::HO_TIMING;
            ho_cnt_q <= 32'h0;
          end else if (frame_end) begin
            ho_q <= asc_pkg::HO_EXPIRED;
          end
        end
        asc_pkg::HO_TIMING: begin
          if (ho_cnt_q == HOLDOFF_LEN - 1) begin
            ho_q <= asc_pkg::HO_EXPIRED;
          end else begin
            ho_cnt_q <= ho_cnt_q + 32'h1;
          end
        end
        default: begin
          ho_q <= asc_pkg::HO_EXPIRED;
        end
      endcase
    end
  end

  logic ho_free;
  assign ho_free = (ho_q == asc_pkg::HO_EXPIRED);

  // one pending software start per qualifying write
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pend_q <= 1'b0;
    end else if (ce_i) begin
      if (sw_req) begin
        pend_q <= 1'b1;
      end else if (ho_free && pend_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  logic go;
  // software start after expiry; hardware edge only when unmasked
  assign go = ho_free && !track_hold_o && !ctrl_q.power_down_bit &&
    (pend_q || (hw_rise && !ctrl_q.software_start_bit));

  // conversion start pulse and track/hold level
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      software_start_bit_start_o <= 1'b0;
      track_hold_o <= 1'b0;
    end else if (ce_i) begin
      software_start_bit_start_o <= go;
      if (go) begin
        track_hold_o <= 1'b1;
      end else if (software_start_bit_done_i) begin
        track_hold_o <= 1'b0;
      end
    end
  end

  // registered copies of control state
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      chan_sel_o <= 3'h0;
      power_down_o <= 1'b0;
      holdoff_timing_cap_o <= 1'b1;
    end else if (ce_i) begin
      chan_sel_o <= ctrl_q.chan_sel;
      power_down_o <= ctrl_q.power_down_bit;
      holdoff_timing_cap_o <= ho_free;
    end
  end

endmodule : asc_ctrl_reg

/* File: dv/asc_ctrl_reg_checker.sv */
`timescale 1ns/1ns
module asc_ctrl_reg_checker (
  // system
  input wire logic mclk_i,
  input wire logic nrst_i,
  // link and engine
  input wire logic write_frame_strobe_n_i,
  input wire logic software_start_bit_done_i,
  // outputs watched
  input wire logic [2:0] chan_sel_o,
  input wire logic power_down_o,
  input wire logic holdoff_timing_cap_o,
  input wire logic track_hold_o,
  input wire logic software_start_bit_start_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_reset_values: assert property ($rose(nrst_i) |-> chan_sel_o == 3'h0 && !power_down_o && holdoff_timing_cap_o)
    else $error("outputs not at reset values");
  a_start_one_cycle: assert property (software_start_bit_start_o |=> !software_start_bit_start_o)
    else $error("start pulse longer than one cycle");
  a_hold_needs_start: assert property ($rose(track_hold_o) |-> software_start_bit_start_o)
    else $error("hold entered without a start");
  a_start_after_holdoff: assert property (software_start_bit_start_o |-> holdoff_timing_cap_o)
    else $error("start while holdoff active");
  a_frame_drops_holdoff: assert property ($fell(write_frame_strobe_n_i) |-> ##[1:6] !holdoff_timing_cap_o)
    else $error("holdoff not driven low at frame start");
  a_chan_launches_holdoff: assert property ($changed(chan_sel_o) |-> !holdoff_timing_cap_o)
    else $error("channel changed without holdoff");
  a_done_releases_hold: assert property (track_hold_o && software_start_bit_done_i |=> !track_hold_o)
    else $error("hold kept after end of conversion");
  a_no_start_standby: assert property (software_start_bit_start_o |-> !power_down_o)
    else $error("start while powered down");
  // ****************************************************************
  // covers
  // ****************************************************************
  c_start: cover property (software_start_bit_start_o);
  c_standby: cover property ($rose(power_down_o));
  c_chan: cover property ($changed(chan_sel_o));
endmodule : asc_ctrl_reg_checker

bind asc_ctrl_reg asc_ctrl_reg_checker asc_ctrl_reg_checker_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .write_frame_strobe_n_i(write_frame_strobe_n_i), .software_start_bit_done_i(software_start_bit_done_i), .chan_sel_o(chan_sel_o),
  .power_down_o(power_down_o), .holdoff_timing_cap_o(holdoff_timing_cap_o), .track_hold_o(track_hold_o),
  .software_start_bit_start_o(software_start_bit_start_o));

/* File: dv/asc_serial_master.sv */
`timescale 1ns/1ns
module asc_serial_master (
  // serial link
  output logic sclk_o,
  output logic strobe_n_o,
  output logic sdata_o
);
  // idle: clock stands high, strobe raised once and left high to arm the link side
  initial begin
    sclk_o = 1'b1;
    strobe_n_o = 1'b0;
    sdata_o = 1'b0;
    #1 strobe_n_o = 1'b1;
  end
  // one write frame of n falling edges, 30 ns clock, msb first
  task send(input logic [4:0] word, input int unsigned n);
    #7 strobe_n_o = 1'b0;
    #20;
    for (int unsigned i = 0; i < n; i++) begin
      sdata_o = (i < 5) ? word[4-i] : ~sdata_o;
      #15 sclk_o = 1'b0;
      #15 sclk_o = 1'b1;
    end
    #15 strobe_n_o = 1'b1;
    sdata_o = ~sdata_o;
    #40;
  endtask : send
endmodule : asc_serial_master

/* File: dv/test_asc_ctrl_reg.sv */
`timescale 1ns/1ns
module test_asc_ctrl_reg;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hw_n = 1'b1;
  logic done = 1'b0;
  logic sclk, tfs_n, sdata;
  logic [2:0] chan_sel;
  logic pd, cap, th, cs;
  int fails = 0;
  int checked = 0;
  int starts = 0;
  // ****************************************************************
  // clock, design and partner
  // ****************************************************************
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (cs === 1'b1) starts++;
  asc_ctrl_reg #(.HOLDOFF_LEN(8)) asc_ctrl_reg_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .sclk_i(sclk), .write_frame_strobe_n_i(tfs_n), .sdata_i(sdata), .hardware_start_n_i(hw_n),
    .software_start_bit_done_i(done), .chan_sel_o(chan_sel), .power_down_o(pd), .holdoff_timing_cap_o(cap),
    .track_hold_o(th), .software_start_bit_start_o(cs));
  asc_serial_master asc_serial_master_inst (.sclk_o(sclk), .strobe_n_o(tfs_n), .sdata_o(sdata));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // frame then settle past the holdoff
  task wr(input logic [4:0] w, input int unsigned n);
    asc_serial_master_inst.send(w, n);
    repeat (30) @(negedge mclk_i);
  endtask : wr
  task software_start_bit_end();
    done = 1'b1;
    @(negedge mclk_i) done = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : software_start_bit_end
  task hw_edge();
    hw_n = 1'b0;
    repeat (4) @(negedge mclk_i);
    hw_n = 1'b1;
    repeat (10) @(negedge mclk_i);
  endtask : hw_edge
  task final_report();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial begin
    #100000;
    fails++;
    final_report();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("reset chan", 5'h00, {2'h0, chan_sel});
    chk("reset standby", 5'h00, {4'h0, pd});
    for (int c = 0; c < 8; c++) begin
      wr({c[2:0], 2'h0}, 6);
      chk("chan", {2'h0, c[2:0]}, {2'h0, chan_sel});
    end
    chk("no start", 5'h00, starts[4:0]);
    wr(5'h14, 5);
    chk("short frame chan", 5'h07, {2'h0, chan_sel});
    wr(5'h0A, 4);
    chk("short start", 5'h01, starts[4:0]);
    chk("short start chan", 5'h07, {2'h0, chan_sel});
    software_start_bit_end();
    wr(5'h0A, 6);
    chk("sw start", 5'h02, starts[4:0]);
    chk("hold", 5'h01, {4'h0, th});
    chk("chan two", 5'h02, {2'h0, chan_sel});
    software_start_bit_end();
    chk("released", 5'h00, {4'h0, th});
    hw_edge();
    chk("hw masked", 5'h02, starts[4:0]);
    wr(5'h0C, 6);
    hw_edge();
    chk("hw start", 5'h03, starts[4:0]);
    software_start_bit_end();
    wr(5'h01, 6);
    chk("standby six", 5'h00, {4'h0, pd});
    wr(5'h01, 7);
    chk("standby", 5'h01, {4'h0, pd});
    wr(5'h00, 7);
    chk("awake", 5'h00, {4'h0, pd});
    chk("expired", 5'h01, {4'h0, cap});
    final_report();
  end
endmodule : test_asc_ctrl_reg
